// *** pkg/slf_pkg.sv ***
// Shared constants and carriers for the self-programming lock and fuse access block.
// Assumes a 25 MHz core clock and an Avalon-MM register master on the same clock.
package slf_pkg;
	// Register word offsets (byte addresses, word aligned)
	localparam logic [3:0] SLF_OFF_CTRL = 4'h0;
	localparam logic [3:0] SLF_OFF_PTR = 4'h4;
	localparam logic [3:0] SLF_OFF_DATA = 4'h8;
	localparam logic [3:0] SLF_OFF_EE = 4'hC;

	// Control/status field positions
	localparam int SLF_BIT_EN = 0;
	localparam int SLF_BIT_ERASE = 1;
	localparam int SLF_BIT_WRITE = 2;
	localparam int SLF_BIT_LFSEL = 3;
	localparam int SLF_BIT_RWWRE = 4;
	localparam int SLF_BIT_RWWB = 6;

	// Command patterns on bits 4..0
	localparam logic [4:0] SLF_CMD_LOCK = 5'h09;
	localparam logic [4:0] SLF_CMD_RWWRE = 5'h11;
	localparam logic [4:0] SLF_CMD_ERASE = 5'h03;
	localparam logic [4:0] SLF_CMD_WRITE = 5'h05;

	// Pointer selections for lock/fuse reads
	localparam logic [15:0] SLF_PTR_FLB = 16'h0000;
	localparam logic [15:0] SLF_PTR_LOCK = 16'h0001;
	localparam logic [15:0] SLF_PTR_EFB = 16'h0002;
	localparam logic [15:0] SLF_PTR_FHB = 16'h0003;

	// Reset values: lock and extended fuse bits unprogrammed (all ones)
	localparam logic [7:0] SLF_RST_LOCK = 8'hFF;
	localparam logic [7:0] SLF_RST_FUSE_LOW = 8'h62;
	localparam logic [7:0] SLF_RST_FUSE_HIGH = 8'h99;
	localparam logic [7:0] SLF_RST_EXT_FUSE = 8'hFF;
	localparam logic [7:0] SLF_EXT_MASK = 8'h0F;

	// Timed windows after the control write
	localparam logic [2:0] SLF_WIN_LOAD = 3'h3;
	localparam logic [2:0] SLF_WIN_STORE = 3'h4;

	// Programming time, timed in core clock (mclk) cycles
	localparam int SLF_CLK_HZ = 25_000_000;
	localparam int SLF_PROG_MIN_US = 3700;
	localparam int SLF_PROG_MAX_US = 4500;
	localparam int SLF_PROG_CYC = (SLF_CLK_HZ / 1000 * SLF_PROG_MIN_US + 999) / 1000;

	// Core instruction strobe group
	typedef struct packed {
		logic store;
		logic load;
		logic [15:0] ptr;
		logic [7:0] r0;
	} slf_core_req_t;

	// Answer to a load instruction
	typedef struct packed {
		logic valid;
		logic fuse_path;
		logic [7:0] data;
	} slf_core_rsp_t;

	typedef enum logic [1:0] {
		SLF_IDLE,
		SLF_ARMED,
		SLF_PROG
	} slf_state_t;
endpackage

// *** hw/slf_lock_fuse.sv ***
// Lock-bit programming and fuse/lock readback for the flash self-programming unit.
// Assumes the core raises store/load strobes for one cycle; the programming timer
// counts mclk cycles.
//
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
module slf_lock_fuse
	import slf_pkg::*;
#(
	parameter int PROG_CYC = SLF_PROG_CYC
) (
	input wire logic mclk,
	input wire logic resetn,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic avs_response_err,
	// Core instruction port
	input wire slf_core_req_t core_req,
	input wire logic [7:0] pmem_byte,
	output slf_core_rsp_t core_rsp,
	// EEPROM engine status
	input wire logic eeprom_write_busy,
	// Fuse values from the nonvolatile array
	input wire logic [7:0] fuse_low_byte,
	input wire logic [7:0] fuse_high_byte,
	input wire logic [7:0] extended_fuse_byte,
	output logic [7:0] lock_byte,
	output logic flash_stall,
	output logic prog_active
);

	slf_state_t state;
	logic [2:0] win_cnt;
	logic [4:0] cmd;
	logic rww_busy;
	logic [15:0] ptr_reg;
	logic [7:0] data_reg;
	logic [31:0] prog_cnt;
	logic lock_pending;
	logic [3:0] boot_lock_new;
	logic ack;
	logic ctrl_wr;
	logic rww_wr;
	logic armed_cmd;
	logic prog_done;

	// Single-cycle answer: waitrequest drops the cycle after a request
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ack <= 1'b0;
		end else begin
			ack <= (avs_read || avs_write) && !ack;
		end
	end
	assign avs_waitrequest = (avs_read || avs_write) && !ack;

	// Write decode; EEPROM busy refuses programming commands
	assign ctrl_wr = avs_write && ack && avs_address == SLF_OFF_CTRL && avs_byteenable[0];
	assign rww_wr = ctrl_wr && avs_writedata[4:0] == SLF_CMD_RWWRE;
	assign armed_cmd = ctrl_wr && avs_writedata[SLF_BIT_EN] && !eeprom_write_busy;

	// Pointer and data holding registers
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ptr_reg <= 16'h0000;
			data_reg <= 8'hFF;
		end else if (avs_write && ack) begin
			if (avs_address == SLF_OFF_PTR) begin
				ptr_reg <= avs_writedata[15:0];
			end
			if (avs_address == SLF_OFF_DATA && avs_byteenable[0]) begin
				data_reg <= avs_writedata[7:0];
			end
		end
	end

	// Timed sequence and programming state
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state <= SLF_IDLE;
			cmd <= 5'h00;
			win_cnt <= 3'h0;
		end else begin
			case (state)
				SLF_IDLE: begin
					if (armed_cmd && !rww_wr) begin
						state <= SLF_ARMED;
						cmd <= avs_writedata[4:0];
						win_cnt <= 3'h0;
					end
				end
				SLF_ARMED: begin
					win_cnt <= win_cnt + 3'h1;
					if (core_req.store && cmd != 5'h01) begin
						state <= SLF_PROG;
					end else if (core_req.load && cmd == SLF_CMD_LOCK) begin
						state <= SLF_IDLE; // Read done, self-clear
					end else if (win_cnt >= SLF_WIN_STORE - 3'h1) begin
						state <= SLF_IDLE; // Window lapsed
					end else if (cmd == SLF_CMD_LOCK && !core_req.store
						&& win_cnt >= SLF_WIN_LOAD - 3'h1 && !core_req.load) begin
						state <= SLF_IDLE; // No load within three cycles
					end
				end
				SLF_PROG: begin
					if (prog_done) begin
						state <= SLF_IDLE;
					end
				end
				default: state <= SLF_IDLE;
			endcase
		end
	end
	assign prog_active = state == SLF_PROG;

	// Programming timer; resetn clears it and returns state to SLF_IDLE, so a reset stops
	// a running write mid-pulse; outside SLF_PROG it is held at zero
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			prog_cnt <= 32'h0000_0000;
		end else if (state == SLF_PROG) begin
			prog_cnt <= prog_cnt + 32'h0000_0001;
		end else begin
			prog_cnt <= 32'h0000_0000;
		end
	end
	assign prog_done = prog_cnt >= 32'(PROG_CYC - 1);

	// Lock write latches only boot lock bits; ptr ignored
	assign boot_lock_new = lock_byte[5:2] & data_reg[5:2];
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			lock_pending <= 1'b0;
		end else if (state == SLF_ARMED && core_req.store && cmd == SLF_CMD_LOCK) begin
			lock_pending <= 1'b1;
		end else if (prog_done) begin
			lock_pending <= 1'b0;
		end
	end
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			lock_byte <= SLF_RST_LOCK;
		end else if (lock_pending && prog_done) begin
			lock_byte <= {lock_byte[7:6], boot_lock_new, lock_byte[1:0]};
		end
	end

	// Lock bits never stall fetch; page ops to the rww area set busy
	assign flash_stall = 1'b0;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rww_busy <= 1'b0;
		end else if (state == SLF_ARMED && core_req.store
			&& (cmd == SLF_CMD_ERASE || cmd == SLF_CMD_WRITE)) begin
			rww_busy <= 1'b1;
		end else if (rww_wr && state != SLF_PROG) begin
			rww_busy <= 1'b0;
		end
	end

	// Load answer: fuse path while armed for lock/fuse, else normal byte
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			core_rsp <= '0;
		end else begin
			core_rsp.valid <= core_req.load;
			core_rsp.fuse_path <= 1'b0;
			core_rsp.data <= pmem_byte;
			if (core_req.load && state == SLF_ARMED && cmd == SLF_CMD_LOCK) begin
				core_rsp.fuse_path <= 1'b1;
				// Raw nonvolatile levels: programmed is 0; extended fuse bits 7..4 read as 1
				case (core_req.ptr)
					SLF_PTR_LOCK: core_rsp.data <= lock_byte;
					SLF_PTR_FLB: core_rsp.data <= fuse_low_byte;
					SLF_PTR_FHB: core_rsp.data <= fuse_high_byte;
					SLF_PTR_EFB: core_rsp.data <= extended_fuse_byte | ~SLF_EXT_MASK;
					default: core_rsp.data <= 8'hFF;
				endcase
			end
		end
	end

	// Register read mux; unmapped reads return zero with error flag
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			avs_readdata <= 32'h0000_0000;
			avs_response_err <= 1'b0;
		end else if (avs_read && !ack) begin
			avs_response_err <= 1'b0;
			case (avs_address)
				SLF_OFF_CTRL: avs_readdata <= {24'h00_0000, 1'b0, rww_busy, 1'b0,
					(state == SLF_ARMED) ? cmd : ((state == SLF_PROG) ? cmd : 5'h00)};
				SLF_OFF_PTR: avs_readdata <= {16'h0000, ptr_reg};
				SLF_OFF_DATA: avs_readdata <= {24'h00_0000, data_reg};
				SLF_OFF_EE: avs_readdata <= {31'h0000_0000, eeprom_write_busy};
				default: begin
					avs_readdata <= 32'h0000_0000;
					avs_response_err <= 1'b1;
				end
			endcase
		end
	end

endmodule // slf_lock_fuse

// *** verif/slf_lock_fuse_chk.sv ***
// Port checker for the lock and fuse access block.
// Assumes one clock and the bind below.
`timescale 1ns/1ns
module slf_lock_fuse_chk
	import slf_pkg::*;
#(
	parameter int PROG_CYC = SLF_PROG_CYC
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [3:0] avs_address,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire slf_core_req_t core_req,
	input wire logic [7:0] pmem_byte,
	input wire slf_core_rsp_t core_rsp,
	input wire logic eeprom_write_busy,
	input wire logic [7:0] lock_byte,
	input wire logic flash_stall,
	input wire logic prog_active
);
	logic [2:0] since;
	int prog_cnt;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// Age of the last control write; saturates so old arms cannot count
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			since <= 3'h7;
		else if (avs_write && !avs_waitrequest && avs_address == SLF_OFF_CTRL)
			since <= 3'h0;
		else if (since != 3'h7)
			since <= since + 3'h1;
	end
	// Length of the current programming run
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			prog_cnt <= 0;
		else
			prog_cnt <= prog_active ? prog_cnt + 1 : 0;
	end
	a_no_stall: assert property (flash_stall == 1'b0) else $error("fetch stalled");
	a_rsp_valid: assert property (core_rsp.valid == $past(core_req.load))
		else $error("load answer timing");
	a_normal_read: assert property (core_req.load && since == 3'h7 |=>
		!core_rsp.fuse_path && core_rsp.data == $past(pmem_byte)) else $error("plain load");
	a_ee_block: assert property (core_req.load && eeprom_write_busy |=>
		!core_rsp.fuse_path) else $error("fuse read under eeprom write");
	a_gen_locks: assert property (lock_byte[1:0] == 2'b11 && lock_byte[7:6] == 2'b11)
		else $error("general lock bits moved");
	a_lock_mono: assert property ((lock_byte & ~$past(lock_byte)) == 8'h00)
		else $error("lock bit unprogrammed");
	a_prog_len: assert property ($fell(prog_active) |-> prog_cnt == PROG_CYC)
		else $error("programming length");
	a_lock_at_end: assert property ($changed(lock_byte) |->
		$past(prog_active) || $past(prog_active, 2)) else $error("lock change outside write");
	c_prog: cover property ($fell(prog_active));
	c_fuse: cover property (core_rsp.valid && core_rsp.fuse_path);
	c_ee: cover property (core_req.load && eeprom_write_busy);
endmodule // slf_lock_fuse_chk

bind slf_lock_fuse slf_lock_fuse_chk #(.PROG_CYC(PROG_CYC)) u_chk (.mclk(mclk),
	.resetn(resetn), .avs_address(avs_address), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .core_req(core_req), .pmem_byte(pmem_byte),
	.core_rsp(core_rsp), .eeprom_write_busy(eeprom_write_busy), .lock_byte(lock_byte),
	.flash_stall(flash_stall), .prog_active(prog_active));

// *** verif/slf_cpu_model.sv ***
// CPU core model issuing timed store and load instructions.
// Assumes calls arrive just after a rising edge.
`timescale 1ns/1ns
module slf_cpu_model
	import slf_pkg::*;
(
	input wire logic mclk,
	output slf_core_req_t core_req,
	output logic [7:0] pmem_byte,
	input wire slf_core_rsp_t core_rsp
);
	initial begin
		core_req = '0;
		pmem_byte = 8'h00;
	end
	// One-cycle strobe right after the control write, answer taken mid-cycle
	task op(input logic st, input logic ld, input logic [15:0] p, output logic [7:0] d,
		output logic fp);
		core_req <= '{store: st, load: ld, ptr: p, r0: 8'hFF};
		pmem_byte <= 8'($urandom);
		@(posedge mclk);
		core_req.store <= 1'b0;
		core_req.load <= 1'b0;
		@(negedge mclk);
		d = core_rsp.data;
		fp = core_rsp.fuse_path;
		@(posedge mclk);
	endtask
endmodule // slf_cpu_model

// *** verif/tb.sv ***
// Self-checking bench: fuse reads, timeouts, lock writes, section busy flag.
// Assumes a short programming count for run time.
`timescale 1ns/1ns
module tb;
	import slf_pkg::*;
	logic mclk = 0, resetn = 0, avs_read = 0, avs_write = 0, ee = 0, wr, err, qe, fp, pa, st;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0000_0000, q, rd;
	logic [7:0] fl, fh, fx, lb, d, pm, expl, r;
	slf_core_req_t req;
	slf_core_rsp_t rsp;
	int n_fail = 0, n_compared = 0, i, k;
	always #20 mclk = ~mclk;
	slf_lock_fuse #(.PROG_CYC(20)) u_slf_lock_fuse (.mclk(mclk), .resetn(resetn),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(rd),
		.avs_waitrequest(wr), .avs_response_err(err), .core_req(req), .pmem_byte(pm),
		.core_rsp(rsp), .eeprom_write_busy(ee), .fuse_low_byte(fl), .fuse_high_byte(fh),
		.extended_fuse_byte(fx), .lock_byte(lb), .flash_stall(st), .prog_active(pa));
	slf_cpu_model u_cpu (.mclk(mclk), .core_req(req), .pmem_byte(pm), .core_rsp(rsp));
	task tally_and_finish;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %0t seen %h exp %h", $time, s, e);
		end
	endtask
	// Held request until waitrequest is seen low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] v);
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= v;
		avs_write <= w;
		avs_read <= !w;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (wr !== 1'b0 && k < 9);
		q = rd;
		qe = err;
		if (wr !== 1'b0) begin
			n_fail++;
			tally_and_finish;
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// Read the EEPROM busy image once and check it before each control write
	task arm(input logic [4:0] c);
		bus(1'b0, SLF_OFF_EE, 32'h0000_0000);
		chk(q, {31'h0000_0000, ee});
		bus(1'b1, SLF_OFF_CTRL, 32'(c));
	endtask
	// Bounded wait for the programming run to end
	task idle;
		repeat (2) @(posedge mclk);
		for (k = 0; k < 99 && pa !== 1'b0; k++) @(negedge mclk);
		if (pa !== 1'b0) begin
			n_fail++;
			tally_and_finish;
		end
		@(posedge mclk);
	endtask
	function logic [7:0] exp_rd(input int p);
		return p == 0 ? fl : p == 1 ? expl : p == 2 ? fx & 8'h0F : fh;
	endfunction
	initial begin
		i = $urandom(26775);
		fl = 8'($urandom);
		fh = 8'($urandom);
		fx = 8'($urandom);
		expl = 8'hFF;
		repeat (10) @(posedge mclk);
		resetn <= 1'b1;
		chk(lb, 8'hFF);
		for (i = 0; i < 4; i++) begin
			arm(SLF_CMD_LOCK);
			u_cpu.op(1'b0, 1'b1, 16'(i), d, fp);
			chk({fp, d & (i == 2 ? 8'h0F : 8'hFF)}, {1'b1, exp_rd(i)});
		end
		// Untimed, late and EEPROM-blocked loads all read program memory
		for (i = 0; i < 3; i++) begin
			ee <= (i == 2);
			if (i > 0)
				arm(SLF_CMD_LOCK);
			if (i == 1)
				repeat (7) @(posedge mclk);
			u_cpu.op(1'b0, 1'b1, SLF_PTR_FLB, d, fp);
			chk({fp, d}, {1'b0, pm});
		end
		bus(1'b1, SLF_OFF_DATA, 32'h0000_00C3);
		arm(SLF_CMD_LOCK);
		u_cpu.op(1'b1, 1'b0, SLF_PTR_LOCK, d, fp);
		idle;
		chk(lb, 8'hFF);
		ee <= 1'b0;
		// Random boot bits, general bits always written high
		for (i = 0; i < 3; i++) begin
			r = 8'($urandom) | 8'hC3;
			expl = expl & r;
			bus(1'b1, SLF_OFF_DATA, 32'(r));
			arm(SLF_CMD_LOCK);
			u_cpu.op(1'b1, 1'b0, 16'($urandom), d, fp);
			idle;
			chk(lb, expl);
			arm(SLF_CMD_LOCK);
			u_cpu.op(1'b0, 1'b1, SLF_PTR_LOCK, d, fp);
			chk(d, expl);
		end
		arm(SLF_CMD_ERASE);
		u_cpu.op(1'b1, 1'b0, 16'h0000, d, fp);
		idle;
		bus(1'b0, SLF_OFF_CTRL, 32'h0000_0000);
		chk(q[SLF_BIT_RWWB], 1'b1);
		arm(SLF_CMD_RWWRE);
		u_cpu.op(1'b1, 1'b0, 16'h0000, d, fp);
		idle;
		bus(1'b0, SLF_OFF_CTRL, 32'h0000_0000);
		chk(q[SLF_BIT_RWWB], 1'b0);
		bus(1'b0, 4'h2, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		chk({31'h0000_0000, qe}, 32'h0000_0001);
		tally_and_finish;
	end
endmodule // tb
